// file: hdl/stopwatch_bcd_timer_pkg.sv
package stopwatch_bcd_timer_pkg;

   // register indices; the byte address on the bus is four times the index
   localparam logic [15:0] IDX_PRIO  = 16'hff20;
   localparam logic [15:0] IDX_EN    = 16'hff22;
   localparam logic [15:0] IDX_FLAGS = 16'hff24;
   localparam logic [15:0] IDX_CTRL  = 16'hff42;
   localparam logic [15:0] IDX_COUNT = 16'hff43;
   localparam logic [15:0] IDX_STAT  = 16'hff44;
   localparam logic [15:0] IDX_MASK  = 16'hff45;

   localparam int unsigned ADR_W = 18;

   // field positions
   localparam int unsigned PRIO_LSB    = 2;  // sw_prio_lo, sw_prio_hi above it
   localparam int unsigned EVT_LSB     = 4;  // seconds, tenths, hundredths upward
   localparam int unsigned CTL_RUN_BIT = 0;  // count_run_bit
   localparam int unsigned CTL_CLR_BIT = 1;  // count_clear_bit

   // values after reset
   localparam logic [1:0] PRIO_RST  = 2'h0;
   localparam logic [2:0] EVT_RST   = 3'h0;
   localparam logic [3:0] DIGIT_RST = 4'h0;
   localparam logic [8:0] ACC_RST   = 9'h000;

   // feedback divider: 100 pulses per 256 ticks
   localparam logic [8:0] ACC_STEP  = 9'h064;
   localparam logic [8:0] ACC_MOD   = 9'h100;
   localparam logic [3:0] DIGIT_MAX = 4'h9;

   // exception vectors
   localparam logic [23:0] VEC_HUND  = 24'h000016;
   localparam logic [23:0] VEC_TENTH = 24'h000018;
   localparam logic [23:0] VEC_SEC   = 24'h00001a;
   localparam logic [23:0] VEC_NONE  = 24'h000000;

   typedef enum logic {
      ST_STOP = 1'b0,
      ST_RUN  = 1'b1
   } run_st_e;

endpackage

// file: hdl/stopwatch_bcd_timer.sv
`timescale 1ns/1ps

// Contract
// - two cascaded BCD digits from 256 Hz tick
// - divider spaces hundredths pulses 2/3 ticks
// - hundredths decade carry gives approximate 10 Hz
// - tenths decade carry gives exact 1 Hz
// - event flags set on each derived edge, except one coinciding with a clear write
// - flags set regardless of enable, priority
// - cpu interrupt needs enable and priority above mask
// - write one clears flag, zero ignored
// - distinct vectors 16H, 18H, 1AH per event
// - two-bit priority field, level zero none
// - three enable bits, reset to zero
// - count byte read-only, tenths high nibble
// - clear bit zeroes count, reads zero
// - run bit starts, stops, holds count
// - run/stop applied at next tick edge
module stopwatch_bcd_timer
   import stopwatch_bcd_timer_pkg::*;
(
   input  wire logic             clk_i,
   input  wire logic             rst_i,
   input  wire logic             tick_256hz_i,
   input  wire logic             cpu_mask_lo_i,
   input  wire logic             cpu_mask_hi_i,
   input  wire logic             cyc_i,
   input  wire logic             stb_i,
   input  wire logic             we_i,
   input  wire logic [ADR_W-1:0] adr_i,
   input  wire logic [3:0]       sel_i,
   input  wire logic [31:0]      dat_i,
   output logic      [31:0]      dat_o,
   output logic                  ack_o,
   output logic                  irq_o,
   output logic                  cpu_irq_o,
   output logic      [1:0]       cpu_irq_level_o,
   output logic      [23:0]      cpu_vector_o
);

   function automatic logic hit(input logic [ADR_W-1:0] adr, input logic [15:0] idx);
      hit = (adr[ADR_W-1:2] == idx);
   endfunction

   logic       tick_q;
   logic       fall;
   run_st_e    run_act_q;
   logic       run_req_q;
   logic       adv;
   logic [8:0] acc_q;
   logic [8:0] acc_sum;
   logic       hund_adv;
   logic       tenth_adv;
   logic       sec_adv;
   logic [3:0] hund_q;
   logic [3:0] tenth_q;
   logic [2:0] ev_q;
   logic [2:0] flags_q;
   logic [2:0] en_q;
   logic [1:0] prio_q;
   logic [2:0] stat_q;
   logic [2:0] mask_q;
   logic       ack_q;
   logic       go;
   logic       wr;
   logic       rd;
   logic       clr_w;
   logic [2:0] flag_clr;
   logic [2:0] pend;
   logic [1:0] cpu_mask;
   logic [7:0] rdata;

   // the tick is synchronous to clk_i; a registered copy gives its falling edge
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         tick_q <= 1'b0;
      end else begin
         tick_q <= tick_256hz_i;
      end
   end

   assign fall = tick_q & ~tick_256hz_i;

   // bus handshake: one access per request, ack drops the cycle after
   assign go    = cyc_i & stb_i & ~ack_q;
   assign wr    = go & we_i & sel_i[0];
   assign rd    = go & ~we_i;
   assign clr_w = wr & hit(adr_i, IDX_CTRL) & dat_i[CTL_CLR_BIT];

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ack_q <= 1'b0;
      end else begin
         ack_q <= go;
      end
   end

   // software view of the run bit
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         run_req_q <= 1'b0;
      end else if (wr && hit(adr_i, IDX_CTRL)) begin
         run_req_q <= dat_i[CTL_RUN_BIT];
      end
   end

   // the request only reaches the counter on a tick edge, so a stop
   // still lets the increment of that same edge through
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         run_act_q <= ST_STOP;
      end else if (fall) begin
         run_act_q <= run_req_q ? ST_RUN : ST_STOP;
      end
   end

   assign adv = fall & (run_act_q == ST_RUN);

   // feedback divider: adding 100 modulo 256 yields pulses 2 or 3 ticks apart
   assign acc_sum  = acc_q + ACC_STEP;
   assign hund_adv = adv & (acc_sum >= ACC_MOD);
   assign tenth_adv = hund_adv & (hund_q == DIGIT_MAX);
   assign sec_adv  = tenth_adv & (tenth_q == DIGIT_MAX);

   // divider phase is cleared with the count so a cleared run starts fresh
   always_ff @(posedge clk_i) begin
      if (rst_i || clr_w) begin
         acc_q <= ACC_RST;
      end else if (adv) begin
         acc_q <= hund_adv ? acc_sum - ACC_MOD : acc_sum;
      end
   end

   // hundredths decade
   always_ff @(posedge clk_i) begin
      if (rst_i || clr_w) begin
         hund_q <= DIGIT_RST;
      end else if (hund_adv) begin
         hund_q <= (hund_q == DIGIT_MAX) ? DIGIT_RST : hund_q + 4'h1;
      end
   end

   // tenths decade; 4 periods of 25 ticks and 6 of 26 make 256
   always_ff @(posedge clk_i) begin
      if (rst_i || clr_w) begin
         tenth_q <= DIGIT_RST;
      end else if (tenth_adv) begin
         tenth_q <= (tenth_q == DIGIT_MAX) ? DIGIT_RST : tenth_q + 4'h1;
      end
   end

   // event strobes: exactly one cycle for each derived falling edge, none in a cycle with a clear write
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ev_q <= EVT_RST;
      end else begin
         ev_q <= {hund_adv, tenth_adv, sec_adv} & {3{~clr_w}};
      end
   end

   // write-one clear; a new event in the same cycle wins
   assign flag_clr = (wr && hit(adr_i, IDX_FLAGS)) ? dat_i[EVT_LSB+2:EVT_LSB] : EVT_RST;

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         flags_q <= EVT_RST;
      end else begin
         flags_q <= (flags_q & ~flag_clr) | ev_q;
      end
   end

   // enables and priority
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         en_q   <= EVT_RST;
         prio_q <= PRIO_RST;
      end else if (wr && hit(adr_i, IDX_EN)) begin
         en_q <= dat_i[EVT_LSB+2:EVT_LSB];
      end else if (wr && hit(adr_i, IDX_PRIO)) begin
         prio_q <= dat_i[PRIO_LSB+1:PRIO_LSB];
      end
   end

   // housekeeping status: sticky, cleared by reading it, event wins
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         stat_q <= EVT_RST;
      end else if (rd && hit(adr_i, IDX_STAT)) begin
         stat_q <= ev_q;
      end else begin
         stat_q <= stat_q | ev_q;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         mask_q <= EVT_RST;
      end else if (wr && hit(adr_i, IDX_MASK)) begin
         mask_q <= dat_i[EVT_LSB+2:EVT_LSB];
      end
   end

   // read mux; bits owned by the neighbouring timer read as zero
   always_comb begin
      rdata = 8'h00;
      if (hit(adr_i, IDX_PRIO)) begin
         rdata[PRIO_LSB+1:PRIO_LSB] = prio_q;
      end else if (hit(adr_i, IDX_EN)) begin
         rdata[EVT_LSB+2:EVT_LSB] = en_q;
      end else if (hit(adr_i, IDX_FLAGS)) begin
         rdata[EVT_LSB+2:EVT_LSB] = flags_q;
      end else if (hit(adr_i, IDX_CTRL)) begin
         rdata[CTL_RUN_BIT] = run_req_q | (run_act_q == ST_RUN);
      end else if (hit(adr_i, IDX_COUNT)) begin
         rdata = {tenth_q, hund_q};
      end else if (hit(adr_i, IDX_STAT)) begin
         rdata[EVT_LSB+2:EVT_LSB] = stat_q;
      end else if (hit(adr_i, IDX_MASK)) begin
         rdata[EVT_LSB+2:EVT_LSB] = mask_q;
      end
   end

   // read data is captured at the acking edge and held until the next read access
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         dat_o <= 32'h00000000;
      end else if (rd) begin
         dat_o <= {24'h000000, rdata};
      end
   end

   assign ack_o = ack_q;

   // cpu request: pending while the flag stays set, so software must clear it
   assign pend     = flags_q & en_q;
   assign cpu_mask = {cpu_mask_hi_i, cpu_mask_lo_i};

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         cpu_irq_o       <= 1'b0;
         cpu_irq_level_o <= PRIO_RST;
         cpu_vector_o    <= VEC_NONE;
         irq_o           <= 1'b0;
      end else begin
         cpu_irq_o       <= (|pend) && (prio_q > cpu_mask);
         cpu_irq_level_o <= prio_q;
         irq_o           <= |(stat_q & mask_q);
         // hundredths first: it is the most frequent and cannot wait long
         if (pend[2]) begin
            cpu_vector_o <= VEC_HUND;
         end else if (pend[1]) begin
            cpu_vector_o <= VEC_TENTH;
         end else if (pend[0]) begin
            cpu_vector_o <= VEC_SEC;
         end else begin
            cpu_vector_o <= VEC_NONE;
         end
      end
   end

   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (rst_i);

   property p_bcd_range;
      (hund_q <= DIGIT_MAX) && (tenth_q <= DIGIT_MAX);
   endproperty
   a_bcd_range: assert property (p_bcd_range)
      else $error("count digit left the decimal range");

   // a remainder below one step keeps the very next tick from pulsing again
   property p_hund_spacing;
      hund_adv |=> (acc_q < ACC_STEP);
   endproperty
   a_hund_spacing: assert property (p_hund_spacing)
      else $error("hundredths pulses closer than two ticks");

   property p_hund_step;
      (adv && !clr_w && acc_q >= 9'h09c) |=> (hund_q != $past(hund_q));
   endproperty
   a_hund_step: assert property (p_hund_step)
      else $error("divider did not advance hundredths");

   property p_tenth_carry;
      (hund_adv && hund_q == DIGIT_MAX && !clr_w) |=> (tenth_q != $past(tenth_q)) && hund_q == 4'h0;
   endproperty
   a_tenth_carry: assert property (p_tenth_carry)
      else $error("hundredths carry lost");

   property p_flag_set;
      ev_q[2] |=> flags_q[2] && stat_q[2];
   endproperty
   a_flag_set: assert property (p_flag_set)
      else $error("event did not set its flag");

   property p_one_pulse;
      ev_q[2] |=> !ev_q[2];
   endproperty
   a_one_pulse: assert property (p_one_pulse)
      else $error("event strobe longer than one cycle");

   property p_flag_clear;
      (wr && hit(adr_i, IDX_FLAGS) && dat_i[EVT_LSB] && !ev_q[0]) |=> !flags_q[0];
   endproperty
   a_flag_clear: assert property (p_flag_clear)
      else $error("write one did not clear flag");

   property p_irq_gate;
      cpu_irq_o |-> $past(prio_q > cpu_mask) && $past(|(flags_q & en_q));
   endproperty
   a_irq_gate: assert property (p_irq_gate)
      else $error("cpu request without enable or priority");

   property p_level0;
      (prio_q == 2'h0) |=> !cpu_irq_o;
   endproperty
   a_level0: assert property (p_level0)
      else $error("level zero raised a request");

   property p_vector;
      cpu_irq_o |-> (cpu_vector_o == VEC_HUND || cpu_vector_o == VEC_TENTH
                     || cpu_vector_o == VEC_SEC);
   endproperty
   a_vector: assert property (p_vector)
      else $error("request with no valid vector");

   property p_clear_count;
      clr_w |=> (hund_q == 4'h0) && (tenth_q == 4'h0);
   endproperty
   a_clear_count: assert property (p_clear_count)
      else $error("clear did not zero the count");

   property p_hold;
      (run_act_q == ST_STOP && !clr_w) |=> $stable({tenth_q, hund_q});
   endproperty
   a_hold: assert property (p_hold)
      else $error("stopped count moved");

   property p_ack;
      go |=> ack_o ##1 !ack_o;
   endproperty
   a_ack: assert property (p_ack)
      else $error("bus answer not one cycle");

endmodule

// file: verif/cpu_side_model.sv
`timescale 1ns/1ps

// stands in for the tick source and the cpu interrupt mask flags
module cpu_side_model (
   input  wire logic       clk_i,
   input  wire logic [1:0] level_i,
   output logic            tick_256hz_o,
   output logic            cpu_mask_lo_o,
   output logic            cpu_mask_hi_o
);
   // the tick idles high, so a burst starts with a clean falling edge
   initial tick_256hz_o = 1'b1;
   // mask flags follow the level that the program sets
   assign cpu_mask_lo_o = level_i[0];
   assign cpu_mask_hi_o = level_i[1];
   // tick period shortened to five clocks to keep the run short
   task automatic emit(input int n);
      repeat (n) begin
         @(posedge clk_i);
         tick_256hz_o <= 1'b0;
         repeat (2) @(posedge clk_i);
         tick_256hz_o <= 1'b1;
         repeat (2) @(posedge clk_i);
      end
      repeat (4) @(posedge clk_i); // lets flag and request registers settle
   endtask
endmodule

// file: verif/tb_stopwatch_bcd_timer.sv
`timescale 1ns/1ps

module tb_stopwatch_bcd_timer
   import stopwatch_bcd_timer_pkg::*;
;
   logic             clk_i = 1'b0;
   logic             rst_i = 1'b1;
   logic             cyc_i;
   logic             stb_i;
   logic             we_i;
   logic [ADR_W-1:0] adr_i;
   logic [3:0]       sel_i;
   logic [31:0]      dat_i;
   logic [1:0]       level;
   logic [31:0]      dat_o;
   logic             ack_o, irq_o, cpu_irq_o, tick, m_lo, m_hi;
   logic [1:0]       cpu_irq_level_o;
   logic [23:0]      cpu_vector_o;
   int               err_count = 0;
   int               n_compared = 0;

   always #12.5 clk_i = ~clk_i;

   stopwatch_bcd_timer stopwatch_bcd_timer_i (.clk_i(clk_i), .rst_i(rst_i),
      .tick_256hz_i(tick), .cpu_mask_lo_i(m_lo), .cpu_mask_hi_i(m_hi), .cyc_i(cyc_i),
      .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i),
      .dat_o(dat_o), .ack_o(ack_o), .irq_o(irq_o), .cpu_irq_o(cpu_irq_o),
      .cpu_irq_level_o(cpu_irq_level_o), .cpu_vector_o(cpu_vector_o));

   cpu_side_model cpu_side_model_i (.clk_i(clk_i), .level_i(level),
      .tick_256hz_o(tick), .cpu_mask_lo_o(m_lo), .cpu_mask_hi_o(m_hi));

   task automatic complete_run();
      $display("compared %0d, errors %0d", n_compared, err_count);
      if (err_count == 0 && n_compared > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp) begin
         err_count++;
         $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask

   // one classic cycle; ack and data are taken at the same sampling edge
   task automatic bus(input logic w, input logic [15:0] idx, input logic [7:0] d,
                      output logic [31:0] q);
      int n;
      n = 0;
      @(posedge clk_i);
      cyc_i <= 1'b1;
      stb_i <= 1'b1;
      we_i  <= w;
      adr_i <= {idx, 2'b00};
      dat_i <= {24'h0, d};
      do begin
         @(posedge clk_i);
         n++;
      end while (ack_o !== 1'b1 && n < 50);
      q = dat_o;
      cyc_i <= 1'b0;
      stb_i <= 1'b0;
      if (n >= 50) begin
         err_count++;
         complete_run();
      end
   endtask

   task automatic wr(input logic [15:0] idx, input logic [7:0] d);
      logic [31:0] q;
      bus(1'b1, idx, d, q);
   endtask

   task automatic rd(input logic [15:0] idx, input logic [7:0] e);
      logic [31:0] q;
      bus(1'b0, idx, 8'h00, q);
      check(q, {24'h0, e});
   endtask

   // request, level and vector after the registered outputs settle
   task automatic req(input logic r, input logic [1:0] l, input logic [23:0] v);
      repeat (3) @(posedge clk_i);
      check({5'h0, cpu_irq_o, cpu_irq_level_o, cpu_vector_o}, {5'h0, r, l, v});
   endtask

   task automatic t_reset();
      rd(IDX_PRIO, 8'h00);
      rd(IDX_EN, 8'h00);
      rd(IDX_FLAGS, 8'h00);
      rd(IDX_CTRL, 8'h00);
      wr(IDX_COUNT, 8'h55);
      rd(IDX_COUNT, 8'h00);
      rd(16'hff30, 8'h00);
      sel_i <= 4'h0;
      wr(IDX_PRIO, 8'h0c);
      sel_i <= 4'h1;
      rd(IDX_PRIO, 8'h00); // byte lane 0 off: write ignored
   endtask

   // divider gives floor(100*n/256) hundredths after n counted ticks
   task automatic t_count();
      wr(IDX_MASK, 8'h40);
      wr(IDX_CTRL, 8'h01);
      cpu_side_model_i.emit(1);
      cpu_side_model_i.emit(5);
      rd(IDX_COUNT, 8'h01);
      cpu_side_model_i.emit(20);
      rd(IDX_COUNT, 8'h09);
      cpu_side_model_i.emit(1);
      rd(IDX_COUNT, 8'h10);
      rd(IDX_FLAGS, 8'h60);
      check({31'h0, irq_o}, 32'h1);
      req(1'b0, 2'h0, VEC_NONE);
      rd(IDX_STAT, 8'h60);
      rd(IDX_STAT, 8'h00);
      check({31'h0, irq_o}, 32'h0);
   endtask

   task automatic t_irq();
      wr(IDX_FLAGS, 8'h00);
      rd(IDX_FLAGS, 8'h60);
      wr(IDX_EN, 8'h70);
      wr(IDX_PRIO, 8'h0c);
      cpu_side_model_i.emit(230);
      rd(IDX_COUNT, 8'h00);
      rd(IDX_FLAGS, 8'h70);
      req(1'b1, 2'h3, VEC_HUND);
      wr(IDX_FLAGS, 8'h40);
      req(1'b1, 2'h3, VEC_TENTH);
      wr(IDX_FLAGS, 8'h20);
      req(1'b1, 2'h3, VEC_SEC);
      level <= 2'h3;
      req(1'b0, 2'h3, VEC_SEC);
      level <= 2'h2;
      req(1'b1, 2'h3, VEC_SEC);
      wr(IDX_PRIO, 8'h00);
      req(1'b0, 2'h0, VEC_SEC);
      wr(IDX_FLAGS, 8'h10);
      rd(IDX_FLAGS, 8'h00);
   endtask

   // stop takes one more tick, and lands on an advance of the divider
   task automatic t_stop();
      wr(IDX_CTRL, 8'h03);
      rd(IDX_COUNT, 8'h00);
      rd(IDX_CTRL, 8'h01);
      cpu_side_model_i.emit(2);
      wr(IDX_CTRL, 8'h00);
      rd(IDX_CTRL, 8'h01);
      cpu_side_model_i.emit(1);
      rd(IDX_COUNT, 8'h01);
      rd(IDX_CTRL, 8'h00);
      cpu_side_model_i.emit(5);
      rd(IDX_COUNT, 8'h01);
      wr(IDX_CTRL, 8'h01);
      cpu_side_model_i.emit(4);
      rd(IDX_COUNT, 8'h02);
   endtask

   initial begin
      cyc_i <= 1'b0;
      stb_i <= 1'b0;
      we_i  <= 1'b0;
      adr_i <= '0;
      sel_i <= 4'h1;
      dat_i <= '0;
      level <= 2'h0;
      repeat (20) @(posedge clk_i);
      rst_i <= 1'b0;
      t_reset();
      t_count();
      t_irq();
      t_stop();
      complete_run();
   end
endmodule
